// >>> rtl/memmap_pkg.sv
// Functional notes
// - split 4 GB into internal memory, external middle, peripherals top four MB.
// - every region uses little-endian byte order only, no big-endian option.
// - 8 KB 32-bit SRAM serves byte, half and word accesses in one cycle.
// - after remap the SRAM answers at address zero, vectors writable.
// - after external reset address zero decodes to boot memory until remap.
// - boot-width select sampled over last 10 cycles before reset release.
// - latched select 1 gives 8-bit boot on chip select zero, 0 gives 16-bit.
// - writing one to the remap command bit swaps boot memory and SRAM.
// - remap undone only by internal or external reset, never by a write.
// - undefined address in external region raises abort.
// - no abort for internal memory reads or any peripheral access.
// - external unit serves 0x0040_0000 up to 0xFFC0_0000.
// - external region is eight banks of 1 MB to 16 MB each, aligned accesses.
// - per bank wait states, float time and 8/16-bit width are programmable.
// - 16-bit banks offer byte-select or byte-write mode.
// - early read protocol selectable per bank.
// - flash addressed as 16-bit words on A1 to A20; A20 kept as address.
// - internal reset does not resample the boot-width select pin.
package memmap_pkg;
  // ****************************************
  // address map
  // ****************************************
  localparam logic [31:0] ext_base = 32'h0040_0000;
  localparam logic [31:0] periph_base = 32'hFFC0_0000;
  localparam int sram_bytes = 8192;
  localparam int sram_aw = 11;
  localparam int bank_count = 8;
  // ****************************************
  // bank configuration field layout
  // ****************************************
  localparam int cfg_wait_lsb = 0;
  localparam int cfg_wait_w = 3;
  localparam int cfg_float_lsb = 3;
  localparam int cfg_float_w = 3;
  localparam int cfg_wide_bit = 6;
  localparam int cfg_bytewr_bit = 7;
  localparam int cfg_early_bit = 8;
  localparam int cfg_w = 9;
  localparam int cfg_size_lsb = 9;
  localparam int cfg_size_w = 2;
  localparam int cfg_enable_bit = 11;
  localparam int bank_cfg_w = 12;
  localparam logic [bank_cfg_w-1:0] bank_cfg_reset = 12'h000;
  // ****************************************
  // timing
  // ****************************************
  localparam int strap_window = 10;
  localparam logic [1:0] size_w = 2'h2;
  localparam logic [1:0] size_h = 2'h1;
  localparam logic [1:0] size_b = 2'h0;
  typedef enum logic [1:0] {region_int, region_ext, region_per} region_t;
endpackage

// >>> rtl/boot_strap_latch.sv
// catches the boot-width select level while external reset is held
module boot_strap_latch
  import memmap_pkg::*;
#(
  parameter int window = strap_window
) (
  input wire logic clk, // master clock
  input wire logic external_reset_n, // pin reset, active low
  input wire logic boot_width_select, // strap level
  output logic boot_narrow // 1: 8-bit boot device
);
  initial begin
    if (window < 1 || window > 255) $error("strap window out of range");
  end
  // power-up values stand in for a reset, since this latch has only the
  // pin that it watches; they keep the window count from staying unknown
  logic [7:0] stable_cnt = 8'h00;
  logic last_level = 1'b0;
  // clocked sampling during reset only; internal resets never reach this
  // block so a watchdog reset keeps the previous boot width
  always_ff @(posedge clk) begin
    if (!external_reset_n) begin
      last_level <= boot_width_select;
      if (boot_width_select != last_level)
        stable_cnt <= 8'h00;
      else if (stable_cnt < 8'(window))
        stable_cnt <= stable_cnt + 8'h01;
      boot_narrow <= boot_width_select;
    end
  end
  // the board must hold the strap level through the whole sampling window
  strap_hold_a: assert property (@(posedge clk)
    $rose(external_reset_n) |-> stable_cnt == 8'(window))
    else $error("strap level moved inside the sampling window");
endmodule

// >>> rtl/memory_map_remap_decoder.sv
module memory_map_remap_decoder
  import memmap_pkg::*;
#(
  parameter int banks = bank_count,
  parameter int sram_words = sram_bytes / 4
) (
  input wire logic clk, // master clock
  input wire logic rst_n, // combined reset, active low
  input wire logic external_reset_n, // pin reset, active low
  input wire logic boot_width_select, // boot width strap
  input wire logic req, // core access request
  input wire logic write, // 1 write, 0 read
  input wire logic fetch, // access is an instruction fetch
  input wire logic [1:0] size, // 0 byte 1 half 2 word
  input wire logic [31:0] addr, // byte address
  input wire logic [31:0] wdata, // write data, little-endian lanes
  output logic [31:0] rdata, // internal SRAM read data
  output logic sram_hit, // access went to SRAM
  output logic ext_sel, // external bus unit selected
  output logic per_sel, // peripheral region selected
  output logic [2:0] bank_sel, // selected chip select number
  output logic [bank_cfg_w-1:0] bank_cfg_out, // selected bank settings
  output logic [20:1] flash_addr, // word address toward flash
  output logic data_abort, // abort on data access
  output logic prefetch_abort, // abort on fetch
  input wire logic remap_command_bit, // remap control register write
  input wire logic [2:0] cfg_bank, // bank being configured
  input wire logic cfg_we, // write bank configuration
  input wire logic [bank_cfg_w-1:0] cfg_data, // new bank configuration
  output logic remapped, // remap state
  output logic boot_narrow // latched boot width, 1 = 8-bit
);
  initial begin
    if (banks != 8) $error("decoder serves exactly eight banks");
    if (sram_words * 4 != sram_bytes) $error("sram size mismatch");
  end
  // every check below runs on the master clock and sleeps through reset
  default clocking main_cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ****************************************
  // boot strap
  // ****************************************
  // the strap latch runs on the pin reset only, so a watchdog reset that
  // pulls rst_n alone leaves the boot width untouched
  boot_strap_latch #(.window(strap_window)) u_strap (
    .clk(clk),
    .external_reset_n(external_reset_n),
    .boot_width_select(boot_width_select),
    .boot_narrow(boot_narrow)
  );
  // ****************************************
  // remap state
  // ****************************************
  // sticky: only reset clears, writes of zero are ignored
  // the command is a one-shot strobe from the remap control register;
  // a write of zero never reaches this port, so nothing can clear the
  // flag short of a reset that pulls rst_n low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) remapped <= 1'b0;
    else if (remap_command_bit) remapped <= 1'b1;
  end
  // ****************************************
  // bank configuration
  // ****************************************
  // eight entries are always kept; the size field decides how much of
  // the external region each one claims, so larger banks simply sit
  // further apart and all eight entries still decode
  logic [bank_cfg_w-1:0] bank_cfg [banks];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < banks; i++) bank_cfg[i] <= bank_cfg_reset;
    end else if (cfg_we) begin
      bank_cfg[cfg_bank] <= cfg_data;
    end
  end
  // ****************************************
  // region decode
  // ****************************************
  // the three regions are told apart by the top ten address bits alone;
  // anything between the internal four megabytes and the peripheral
  // four megabytes belongs to the external bus unit, holes included, so
  // an unmapped hole there is what raises the abort further down
  wire in_int = addr < ext_base;
  wire in_per = addr >= periph_base;
  wire in_ext = !in_int && !in_per;
  wire [31:0] ext_off = addr - ext_base;
  wire boot_view = !remapped && in_int;
  wire sram_view = in_int && remapped;
  // bank lookup: each enabled bank maps size field 0..3 to 1/2/4/16 MB
  // from its own base; bank n base is n times the 16 MB stride when size 3
  // limitation: overlapping banks are resolved by the lowest index; the
  // loop unrolls into eight comparators, traded for a short decode path
  // instead of a registered lookup that would cost a cycle
  logic [2:0] hit_bank;
  logic hit_any;
  always_comb begin
    logic [3:0] mb_shift;
    logic [31:0] span;
    logic [31:0] base;
    mb_shift = 4'h0;
    span = 32'h0;
    base = 32'h0;
    hit_bank = 3'h0;
    hit_any = 1'b0;
    for (int i = 0; i < banks; i++) begin
      unique case (bank_cfg[i][cfg_size_lsb +: cfg_size_w])
        2'h0: mb_shift = 4'h0;
        2'h1: mb_shift = 4'h1;
        2'h2: mb_shift = 4'h2;
        2'h3: mb_shift = 4'h4;
      endcase
      span = 32'h0010_0000 << mb_shift;
      base = 32'(i) * span;
      if (bank_cfg[i][cfg_enable_bit] && !hit_any &&
          ext_off >= base && ext_off < base + span) begin
        hit_bank = 3'(i);
        hit_any = 1'b1;
      end
    end
  end
  // during boot the bus unit has been configured for nothing yet, so the
  // boot device borrows wait and float counts from bank zero while its
  // width comes from the strap; early read and byte write stay off so a
  // slow nonvolatile part answers reliably
  // chip select zero is always defined while the boot view is active
  wire ext_access = in_ext || boot_view;
  wire ext_defined = boot_view || hit_any;
  wire [2:0] next_bank = boot_view ? 3'h0 : hit_bank;
  wire [bank_cfg_w-1:0] boot_cfg = {bank_cfg_reset[bank_cfg_w-1:cfg_w],
    1'b0, 1'b0, !boot_narrow, bank_cfg[0][5:0]};
  // a misaligned word or half word in the external region aborts even on
  // a defined bank, since the banks accept aligned accesses only
  wire misaligned = (size == size_w && addr[1:0] != 2'h0) ||
                    (size == size_h && addr[0]);
  wire abort_hit = req && in_ext && (!ext_defined || misaligned);
  // ****************************************
  // internal SRAM
  // ****************************************
  // write side only; the read path sits in the answer register below so
  // read data leaves from a flip-flop. an address past the top of the SRAM
  // inside the internal region gives neither a hit nor an abort
  logic [31:0] sram [sram_words];
  wire [sram_aw-1:0] widx = addr[sram_aw+1:2];
  wire sram_go = req && sram_view && addr < 32'(sram_bytes);
  // little-endian lane enables, lane 0 at the lowest address
  wire [3:0] lanes = (size == size_w) ? 4'hF :
                     (size == size_h) ? (addr[1] ? 4'hC : 4'h3) :
                     (4'h1 << addr[1:0]);
  always_ff @(posedge clk) begin
    if (sram_go && write) begin
      for (int b = 0; b < 4; b++)
        if (lanes[b]) sram[widx][8*b +: 8] <= wdata[8*b +: 8];
    end
  end
  // ****************************************
  // registered answer, one cycle after request
  // ****************************************
  // every output is recomputed each cycle and stands for exactly one
  // cycle; the core takes it at the next edge. a read that misses the
  // SRAM returns zero rather than stale data, which keeps the read bus
  // quiet while the external path brings its own data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0;
      sram_hit <= 1'b0;
      ext_sel <= 1'b0;
      per_sel <= 1'b0;
      bank_sel <= 3'h0;
      bank_cfg_out <= bank_cfg_reset;
      flash_addr <= 20'h0;
      data_abort <= 1'b0;
      prefetch_abort <= 1'b0;
    end else begin
      rdata <= (sram_go && !write) ? sram[widx] : 32'h0;
      sram_hit <= sram_go;
      ext_sel <= req && ext_access && ext_defined && !misaligned;
      per_sel <= req && in_per;
      bank_sel <= next_bank;
      bank_cfg_out <= boot_view ? boot_cfg : bank_cfg[hit_bank];
      // flash word address keeps A20 as address line
      flash_addr <= boot_view ? addr[20:1] : ext_off[20:1];
      data_abort <= abort_hit && !fetch;
      prefetch_abort <= abort_hit && fetch;
    end
  end
  // ****************************************
  // checks: region decode and aborts
  // ****************************************
  // every check samples one cycle after the taking edge, matching the
  // registered answer; reset masks them through the default disable
  no_abort_int_a: assert property
    (req && !in_ext |=> !data_abort && !prefetch_abort)
    else $error("abort outside external region");
  per_no_abort_a: assert property
    (req && in_per |=> per_sel && !data_abort && !prefetch_abort)
    else $error("abort on peripheral access");
  undef_abort_a: assert property
    (req && in_ext && !ext_defined && !fetch |=> data_abort)
    else $error("missing abort on undefined address");
  undef_fetch_a: assert property
    (req && in_ext && !ext_defined && fetch |=> prefetch_abort)
    else $error("missing prefetch abort on undefined address");
  abort_kind_a: assert property
    (!(data_abort && prefetch_abort))
    else $error("both abort kinds raised at once");
  misalign_abort_a: assert property
    (req && in_ext && misaligned && !fetch |=> data_abort && !ext_sel)
    else $error("misaligned external access not aborted");
  half_align_a: assert property
    (req && in_ext && size == size_h && addr[0] && !fetch |=> data_abort)
    else $error("odd half word access not aborted");
  ext_region_a: assert property
    (req && in_ext && ext_defined && !misaligned |=>
     ext_sel && !per_sel && !sram_hit)
    else $error("external access not routed to the bus unit");
  ext_no_sram_a: assert property
    (req && in_ext |=> !sram_hit)
    else $error("sram answered an external address");
  per_region_a: assert property
    (req && addr >= 32'hFFC0_0000 |=> per_sel && !ext_sel)
    else $error("peripheral decode wrong");
  int_not_per_a: assert property
    (req && addr < 32'h0040_0000 |=> !per_sel)
    else $error("internal address seen as peripheral");
  sram_range_a: assert property
    (req && in_int && addr >= 32'(sram_bytes) |=> !sram_hit)
    else $error("sram answered past its top");
  idle_quiet_a: assert property
    (!req |=> !sram_hit && !ext_sel && !per_sel && !data_abort &&
     !prefetch_abort)
    else $error("answer without request");
  // ****************************************
  // checks: boot view and remap
  // ****************************************
  // the strap width is only carried while the boot view is active; after a
  // remap chip select zero uses its programmed width like any other bank
  boot_zero_a: assert property
    (req && !remapped && addr == 32'h0 |=>
     ext_sel && bank_sel == 3'h0 && !sram_hit)
    else $error("boot fetch not on chip select zero");
  boot_no_sram_a: assert property
    (req && !remapped && in_int |=> !sram_hit)
    else $error("sram visible before remap");
  boot_bank_a: assert property
    (req && !remapped && in_int |=> bank_sel == 3'h0)
    else $error("boot view not on chip select zero");
  boot_width_a: assert property
    (req && !remapped && in_int |=>
     bank_cfg_out[cfg_wide_bit] == !$past(boot_narrow))
    else $error("boot width not from strap");
  boot_plain_a: assert property
    (req && !remapped && in_int |=>
     !bank_cfg_out[cfg_early_bit] && !bank_cfg_out[cfg_bytewr_bit])
    else $error("boot device not in plain read mode");
  boot_wait_a: assert property
    (req && !remapped && in_int |=>
     bank_cfg_out[cfg_wait_lsb +: cfg_wait_w] ==
     $past(bank_cfg[0][cfg_wait_lsb +: cfg_wait_w]))
    else $error("boot wait states not from bank zero");
  flash_a20_a: assert property
    (req && !remapped && in_int |=> flash_addr == $past(addr[20:1]))
    else $error("flash word address lost a line");
  flash_ext_a: assert property
    (req && in_ext |=> flash_addr == $past(ext_off[20:1]))
    else $error("external word address wrong");
  remap_sticky_a: assert property
    (remapped |=> remapped)
    else $error("remap undone without reset");
  remap_only_cmd_a: assert property
    (!remapped && !remap_command_bit |=> !remapped)
    else $error("remap without command");
  remap_take_a: assert property
    (remap_command_bit |=> remapped)
    else $error("remap not applied");
  sram_zero_a: assert property
    (req && remapped && addr < 32'h20 |=> sram_hit && !ext_sel)
    else $error("sram not at zero after remap");
  // ****************************************
  // checks: internal SRAM and banks
  // ****************************************
  // readback is checked on a write followed at once by a read of the same
  // word, the tightest case for the single-cycle claim
  sram_one_cycle_a: assert property
    (req && remapped && addr < 32'(sram_bytes) |=> sram_hit)
    else $error("sram access not answered next cycle");
  rdata_quiet_a: assert property
    (req && write |=> rdata == 32'h0)
    else $error("read data driven on a write");
  sram_word_a: assert property
    (sram_go && write && size == size_w ##1
     req && !write && size == size_w && $past(addr) == addr && sram_go
     |=> rdata == $past(wdata, 2))
    else $error("sram word readback wrong");
  bank_cfg_sel_a: assert property
    (cfg_we ##1 req && in_ext && hit_any && hit_bank == $past(cfg_bank)
     |=> bank_cfg_out == $past(cfg_data, 2) &&
     bank_sel == $past(cfg_bank, 2))
    else $error("bank settings not taken from the written bank");
endmodule

// >>> dv/board_model.sv
// board side of the strap pin: holds the boot width during pin reset
module board_model (
  input wire logic clk, // master clock
  input wire logic external_reset_n, // pin reset, active low
  input wire logic strap_level, // level the board straps
  output logic boot_width_select // shared strap and io pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic io_level = 1'b0;
  // after reset the pin is a plain io line; it toggles so a late sample shows
  always @(posedge clk) begin
    io_level <= ~io_level;
  end
  // strap held steady through the whole reset; flash boot straps it low
  assign boot_width_select =
    external_reset_n ? io_level : strap_level;
endmodule

// >>> dv/memory_map_remap_decoder_bench.sv
module memory_map_remap_decoder_bench;
  import memmap_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, external_reset_n = 0, strap_level = 1;
  logic req = 0, write = 0, fetch = 0, remap_command_bit = 0, cfg_we = 0;
  logic [1:0] size = 2'h0;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata;
  logic [2:0] cfg_bank = 3'h0, bank_sel;
  logic [bank_cfg_w-1:0] cfg_data = 12'h000, bank_cfg_out;
  logic [20:1] flash_addr;
  logic boot_width_select, sram_hit, ext_sel, per_sel, data_abort;
  logic prefetch_abort, remapped, boot_narrow;
  int error_cnt = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  board_model partner (.clk, .external_reset_n, .strap_level,
    .boot_width_select);
  memory_map_remap_decoder dut (.clk, .rst_n, .external_reset_n,
    .boot_width_select, .req, .write, .fetch, .size, .addr, .wdata, .rdata,
    .sram_hit, .ext_sel, .per_sel, .bank_sel, .bank_cfg_out, .flash_addr,
    .data_abort, .prefetch_abort, .remap_command_bit, .cfg_bank, .cfg_we,
    .cfg_data, .remapped, .boot_narrow);
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one access; answers are looked at on the falling edge half a cycle after the taking edge
  task automatic acc(input logic w, f, input logic [1:0] sz,
                     input logic [31:0] a, d);
    @(negedge clk);
    remap_command_bit = 0;
    cfg_we = 0;
    req = 1;
    write = w;
    fetch = f;
    size = sz;
    addr = a;
    wdata = d;
    @(negedge clk);
    req = 0;
  endtask
  // pin reset when pin is set, otherwise an internal reset only
  task automatic reset_pin(input logic pin, input logic strap);
    @(negedge clk);
    strap_level = strap;
    rst_n = 0;
    external_reset_n = ~pin;
    repeat (12) @(negedge clk);
    rst_n = 1;
    external_reset_n = 1;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic boot_view(input logic narrow);
    chk("boot_narrow", boot_narrow, narrow);
    @(negedge clk);
    cfg_bank = 3'h0;
    cfg_data = 12'h005;
    cfg_we = 1;
    acc(0, 1, size_h, 32'h0000_0006, 32'h0);
    chk("boot wait", bank_cfg_out[5:0], 6'h05);
    chk("boot ext_sel", ext_sel, 1'b1);
    chk("boot sram_hit", sram_hit, 1'b0);
    chk("boot bank", bank_sel, 3'h0);
    chk("boot width", bank_cfg_out[cfg_wide_bit], !narrow);
    chk("boot flash_addr", flash_addr, 20'h00003);
    chk("boot abort", prefetch_abort, 1'b0);
  endtask
  task automatic sram_remap();
    chk("remapped early", remapped, 1'b0);
    @(negedge clk);
    remap_command_bit = 1;
    acc(1, 0, size_w, 32'h0, 32'h1122_3344);
    chk("remapped", remapped, 1'b1);
    chk("first hit", sram_hit, 1'b1);
    chk("first ext", ext_sel, 1'b0);
    acc(1, 0, size_b, 32'h1, 32'h0000_AA00);
    acc(1, 0, size_h, 32'h2, 32'hBEEF_0000);
    acc(0, 1, size_w, 32'h0, 32'h0);
    chk("lane merge", rdata, 32'hBEEF_AA44);
    chk("fetch hit", sram_hit, 1'b1);
    @(negedge clk);
    req = 1;
    write = 1;
    fetch = 0;
    size = size_w;
    addr = 32'h1FFC;
    wdata = 32'hCAFE_F00D;
    @(negedge clk);
    write = 0;
    @(negedge clk);
    req = 0;
    chk("top word", rdata, 32'hCAFE_F00D);
    chk("top hit", sram_hit, 1'b1);
    acc(0, 0, size_w, 32'h2000, 32'h0);
    chk("past sram", sram_hit, 1'b0);
    chk("int abort", data_abort, 1'b0);
    acc(1, 0, size_w, 32'hFFFF_FFF0, 32'h5);
    chk("per_sel", per_sel, 1'b1);
    chk("per abort", data_abort, 1'b0);
  endtask
  task automatic ext_banks();
    acc(0, 0, size_w, 32'h0F00_0000, 32'h0);
    chk("undef data", data_abort, 1'b1);
    chk("undef pre", prefetch_abort, 1'b0);
    acc(0, 1, size_w, 32'h0F00_0000, 32'h0);
    chk("undef fetch", prefetch_abort, 1'b1);
    chk("undef fetch d", data_abort, 1'b0);
    @(negedge clk);
    cfg_bank = 3'h1;
    cfg_data = 12'h955;
    cfg_we = 1;
    acc(0, 0, size_w, 32'h0050_0008, 32'h0);
    chk("bank ext", ext_sel, 1'b1);
    chk("bank sel", bank_sel, 3'h1);
    chk("bank cfg", bank_cfg_out, 12'h955);
    chk("bank ok", data_abort, 1'b0);
    acc(1, 0, size_h, 32'h0050_0002, 32'h1234_0000);
    chk("half ok", data_abort, 1'b0);
    acc(0, 0, size_w, 32'h0050_0002, 32'h0);
    chk("misaligned", data_abort, 1'b1);
  endtask
  task automatic remap_sticky();
    @(negedge clk);
    remap_command_bit = 1;
    acc(0, 0, size_w, 32'h0, 32'h0);
    chk("still remapped", sram_hit, 1'b1);
    reset_pin(0, 0);
    chk("internal undo", remapped, 1'b0);
    boot_view(1);
    reset_pin(1, 0);
    chk("pin undo", remapped, 1'b0);
    boot_view(0);
  endtask
  // ****************************************
  // main sequence and hang guard
  // ****************************************
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    external_reset_n = 1;
    boot_view(1);
    sram_remap();
    ext_banks();
    remap_sticky();
    report_and_stop();
  end
  initial begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule
